//--- dvs_pkg.sv
/*
  Constants, types and register map of the digital volume stage.
  Assumes one clock domain (ref_clk) and a plain byte-wide register port.
*/

package dvs_pkg;

  // -------------------------------------------------------------------
  // Register map
  // -------------------------------------------------------------------
  localparam logic [7:0] REG_STEP_CTRL = 8'h00;
  localparam logic [7:0] REG_MUTE_CTRL = 8'h01;
  localparam logic [7:0] REG_VOL_GAIN  = 8'h02;
  localparam logic [7:0] REG_FILT_SEL  = 8'h03;
  localparam logic [7:0] REG_GAIN_STAT = 8'h04;
  localparam logic [7:0] REG_POT_CTRL  = 8'h05;
  localparam logic [7:0] REG_POT_GAIN  = 8'h06;
  localparam logic [7:0] REG_INT_STAT  = 8'h07;
  localparam logic [7:0] REG_INT_CLR   = 8'h08;
  localparam logic [7:0] REG_INT_EN    = 8'h09;

  // -------------------------------------------------------------------
  // Field positions
  // -------------------------------------------------------------------
  localparam int MUTE_BIT     = 3;
  localparam int MASTER_BIT   = 1;
  localparam int REACHED_BIT  = 4;
  localparam int POT_SRC_BIT  = 7;
  localparam int POT_CLK_BIT  = 6;
  localparam int INT_REACHED  = 0;
  localparam int INT_POT      = 1;
  localparam int INT_W        = 2;

  // -------------------------------------------------------------------
  // Gain arithmetic: register in half dB, applied gain in eighth dB
  // -------------------------------------------------------------------
  localparam logic signed [7:0]  GAIN_MAX_HALF  = 8'sh30;  // +24 dB
  localparam logic signed [7:0]  GAIN_MIN_HALF  = -8'sh7f; // -63.5 dB
  localparam logic signed [7:0]  GAIN_RST_HALF  = 8'sh00;
  localparam logic signed [10:0] STEP_Q         = 11'sh001; // 0.125 dB
  localparam logic signed [10:0] MUTE_Q         = -11'sh208; // below range
  localparam logic [6:0]         POT_FINE_LAST  = 7'h5a;  // code 90
  localparam logic [6:0]         POT_MUTE_CODE  = 7'h7f;  // code 127
  localparam logic signed [8:0]  POT_FINE_OFS   = 9'sh024; // 18 dB
  localparam logic signed [8:0]  POT_COARSE_OFS = 9'sh07e;

  // -------------------------------------------------------------------
  // Interpolation filter group delays, in sample periods
  // -------------------------------------------------------------------
  localparam logic [1:0] FILT_A  = 2'h0;
  localparam logic [1:0] FILT_B  = 2'h1;
  localparam logic [1:0] FILT_C  = 2'h2;
  localparam int         DELAY_A = 21;
  localparam int         DELAY_B = 18;
  localparam int         DELAY_C = 13;
  localparam int         DATA_W  = 24;

  // Samples between SAR conversions at rate field zero
  localparam int         POT_UPD_BASE = 16;

  typedef enum logic [1:0] {
    STEP_NORMAL = 2'b00,
    STEP_HALF   = 2'b01,
    STEP_OFF    = 2'b10,
    STEP_OFF2   = 2'b11
  } dvs_step_e;

  typedef enum logic [1:0] {
    SAR_IDLE = 2'b00,
    SAR_WAIT = 2'b01,
    SAR_DROP = 2'b10
  } dvs_sar_e;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } dvs_sample_s;

  typedef struct packed {
    logic signed [7:0]  vol_half;
    logic               mute;
    logic               master;
    dvs_step_e          step_mode;
    logic [1:0]         filt_sel;
    logic               pot_src;
    logic               pot_clk;
    logic [2:0]         pot_rate;
    logic [6:0]         pot_code;
    logic               pot_mute;
    logic signed [10:0] applied;
    logic               half_phase;
    logic               reached;
    logic [INT_W-1:0]   int_stat;
    logic [INT_W-1:0]   int_en;
    logic [7:0]         rdata;
    dvs_sar_e           sar_st;
    logic [15:0]        upd_cnt;
    dvs_sample_s        out;
  } dvs_state_s;

endpackage

//--- dvs_volume.sv
/*
  Digital playback volume stage: soft-stepped gain, mute, volume-pin
  SAR control, interpolation delay and an interrupt.
  Assumes the sample stream is synchronous to ref_clk and that the SAR
  converter answers a four-phase request/acknowledge handshake from its
  own clock, holding its code while acknowledge is high.
*/
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module dvs_volume
  import dvs_pkg::*;
#(
  parameter int DEPTH = DELAY_A
) (
  input  wire logic               ref_clk,
  input  wire logic               sys_rst,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [7:0]         reg_rdata,
  input  wire dvs_sample_s        sample_in,
  output dvs_sample_s             sample_out,
  output logic signed [10:0]      applied_gain_q,
  output logic                    channel_muted,
  output logic                    gain_master,
  input  wire logic               dac_power_req,
  output logic                    dac_power_flag,
  output logic                    sar_req,
  input  wire logic               sar_ack,
  input  wire logic [6:0]         sar_code,
  output logic                    sar_clk_sel,
  output logic                    irq
);

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  dvs_state_s        s_r;
  dvs_state_s        s_nxt;
  logic [DATA_W-1:0] dly_r [DEPTH];
  logic              ack_s1_r;
  logic              ack_s2_r;
  logic [6:0]        code_s1_r;
  logic [6:0]        code_s2_r;

  localparam dvs_state_s STATE_RST = '{
    vol_half:   GAIN_RST_HALF,
    mute:       1'b0,
    master:     1'b0,
    step_mode:  STEP_NORMAL,
    filt_sel:   FILT_A,
    pot_src:    1'b0,
    pot_clk:    1'b0,
    pot_rate:   3'h0,
    pot_code:   7'h00,
    pot_mute:   1'b0,
    applied:    MUTE_Q,
    half_phase: 1'b0,
    reached:    1'b0,
    int_stat:   '0,
    int_en:     '0,
    rdata:      8'h00,
    sar_st:     SAR_IDLE,
    upd_cnt:    16'h0000,
    out:        '0
  };

  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------

  // SAR code to gain in half dB; code 127 is handled as mute by caller
  function automatic logic signed [7:0] pot_to_half(
    input logic [6:0] c
  );
    logic signed [8:0] t;
    t = 9'sh000;
    if (c <= POT_FINE_LAST) begin
      t = POT_FINE_OFS - $signed({2'b00, c});
    end else if (c == POT_MUTE_CODE) begin
      t = 9'(GAIN_MIN_HALF);
    end else begin
      t = POT_COARSE_OFS - $signed({1'b0, c, 1'b0});
    end
    return t[7:0];
  endfunction

  // Clamp a written gain into the documented span; codes above +24 dB
  // are reserved, so they saturate rather than wrap into attenuation
  function automatic logic signed [7:0] clamp_half(
    input logic signed [7:0] h
  );
    logic signed [7:0] r;
    r = h;
    if (h > GAIN_MAX_HALF) begin
      r = GAIN_MAX_HALF;
    end else if (h < GAIN_MIN_HALF) begin
      r = GAIN_MIN_HALF;
    end
    return r;
  endfunction

  // -------------------------------------------------------------------
  // Synchronisers for the SAR converter side
  // -------------------------------------------------------------------

  // Code is bundled with acknowledge; both pass two flops
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ack_s1_r  <= 1'b0;
      ack_s2_r  <= 1'b0;
      code_s1_r <= 7'h00;
      code_s2_r <= 7'h00;
    end else begin
      ack_s1_r  <= sar_ack;
      ack_s2_r  <= ack_s1_r;
      code_s1_r <= sar_code;
      code_s2_r <= code_s1_r;
    end
  end

  // -------------------------------------------------------------------
  // Interpolation delay line
  // -------------------------------------------------------------------

  // Sized for the longest filter; shorter filters tap earlier
  always_ff @(posedge ref_clk) begin
    if (sample_in.valid) begin
      dly_r[0] <= sample_in.data;
    end
  end

  for (genvar i = 1; i < DEPTH; i++) begin : g_dly
    always_ff @(posedge ref_clk) begin
      if (sample_in.valid) begin
        dly_r[i] <= dly_r[i-1];
      end
    end
  end

  // -------------------------------------------------------------------
  // Next-state logic
  // -------------------------------------------------------------------
  logic signed [10:0] target_q;
  logic               step_now;
  logic [15:0]        upd_last;
  logic [INT_W-1:0]   events;
  logic [INT_W-1:0]   clr_mask;
  logic [4:0]         tap;

  always_comb begin
    s_nxt    = s_r;
    events   = '0;
    clr_mask = '0;
    target_q = MUTE_Q;
    step_now = 1'b0;
    tap      = 5'(DELAY_A - 1);
    upd_last = 16'((POT_UPD_BASE << s_r.pot_rate) - 1);

    // Register writes; the SAR may overwrite the gain below
    if (reg_wr) begin
      unique case (reg_addr)
        REG_STEP_CTRL: s_nxt.step_mode = dvs_step_e'(reg_wdata[1:0]);
        REG_MUTE_CTRL: begin
          s_nxt.mute   = reg_wdata[MUTE_BIT];
          s_nxt.master = reg_wdata[MASTER_BIT];
        end
        REG_VOL_GAIN: begin
          if (!s_r.pot_src) begin
            s_nxt.vol_half = clamp_half($signed(reg_wdata));
          end
        end
        REG_FILT_SEL:  s_nxt.filt_sel = reg_wdata[1:0];
        REG_POT_CTRL: begin
          s_nxt.pot_src  = reg_wdata[POT_SRC_BIT];
          s_nxt.pot_clk  = reg_wdata[POT_CLK_BIT];
          s_nxt.pot_rate = reg_wdata[2:0];
        end
        REG_INT_CLR:   clr_mask = reg_wdata[INT_W-1:0];
        REG_INT_EN:    s_nxt.int_en = reg_wdata[INT_W-1:0];
        default: begin
        end
      endcase
    end

    // Volume-pin conversion: paced in samples, four-phase handshake
    unique case (s_r.sar_st)
      SAR_IDLE: begin
        if (!s_r.pot_src) begin
          s_nxt.upd_cnt = 16'h0000;
        end else if (sample_in.valid) begin
          if (s_r.upd_cnt >= upd_last) begin
            s_nxt.upd_cnt = 16'h0000;
            s_nxt.sar_st  = SAR_WAIT;
          end else begin
            s_nxt.upd_cnt = s_r.upd_cnt + 16'h0001;
          end
        end
      end
      SAR_WAIT: begin
        if (ack_s2_r) begin
          s_nxt.sar_st = SAR_DROP;
          // Leaving pin mode mid-conversion discards the result
          if (s_r.pot_src) begin
            s_nxt.pot_code = code_s2_r;
            s_nxt.vol_half = pot_to_half(code_s2_r);
            s_nxt.pot_mute = (code_s2_r == POT_MUTE_CODE);
            events[INT_POT] = 1'b1;
          end
        end
      end
      SAR_DROP: begin
        if (!ack_s2_r) begin
          s_nxt.sar_st = SAR_IDLE;
        end
      end
      default: s_nxt.sar_st = SAR_IDLE;
    endcase

    // Pin mute only counts while the pin is the source
    if (!s_nxt.pot_src) begin
      s_nxt.pot_mute = 1'b0;
    end

    // Target in eighth dB; power-down ramps to mute first
    if (s_r.mute || (s_r.pot_src && s_r.pot_mute) || !dac_power_req) begin
      target_q = MUTE_Q;
    end else begin
      target_q = {{1{s_r.vol_half[7]}}, s_r.vol_half, 2'b00};
    end

    // Soft-step pacing
    unique case (s_r.step_mode)
      STEP_NORMAL: step_now = sample_in.valid;
      STEP_HALF: begin
        if (sample_in.valid) begin
          s_nxt.half_phase = !s_r.half_phase;
        end
        step_now = sample_in.valid && s_r.half_phase;
      end
      STEP_OFF, STEP_OFF2: step_now = 1'b0;
    endcase

    // Move applied gain one step toward target, or jump when off
    if (s_r.step_mode == STEP_OFF || s_r.step_mode == STEP_OFF2) begin
      s_nxt.applied = target_q;
    end else if (step_now) begin
      if (s_r.applied < target_q) begin
        s_nxt.applied = s_r.applied + STEP_Q;
      end else if (s_r.applied > target_q) begin
        s_nxt.applied = s_r.applied - STEP_Q;
      end
    end

    // Reached flag tracks the comparison every cycle
    s_nxt.reached = (s_nxt.applied == target_q);
    if (!s_r.reached && s_nxt.reached) begin
      events[INT_REACHED] = 1'b1;
    end

    // Sticky status: a new event wins over a same-cycle clear
    s_nxt.int_stat = (s_r.int_stat & ~clr_mask) | events;

    // Group delay chosen by the interpolation filter
    unique case (s_r.filt_sel)
      FILT_B:  tap = 5'(DELAY_B - 1);
      FILT_C:  tap = 5'(DELAY_C - 1);
      default: tap = 5'(DELAY_A - 1);
    endcase
    s_nxt.out.valid = sample_in.valid;
    if (sample_in.valid) begin
      s_nxt.out.data = dly_r[tap];
    end

    // Read data lands in the cycle after the strobe only
    s_nxt.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_STEP_CTRL: s_nxt.rdata = {6'h00, s_r.step_mode};
        REG_MUTE_CTRL: begin
          s_nxt.rdata[MUTE_BIT]   = s_r.mute;
          s_nxt.rdata[MASTER_BIT] = s_r.master;
        end
        REG_VOL_GAIN:  s_nxt.rdata = s_r.vol_half;
        REG_FILT_SEL:  s_nxt.rdata = {6'h00, s_r.filt_sel};
        REG_GAIN_STAT: s_nxt.rdata[REACHED_BIT] = s_r.reached;
        REG_POT_CTRL: begin
          s_nxt.rdata[POT_SRC_BIT] = s_r.pot_src;
          s_nxt.rdata[POT_CLK_BIT] = s_r.pot_clk;
          s_nxt.rdata[2:0]         = s_r.pot_rate;
        end
        REG_POT_GAIN:  s_nxt.rdata = {1'b0, s_r.pot_code};
        REG_INT_STAT:  s_nxt.rdata = {6'h00, s_r.int_stat};
        REG_INT_EN:    s_nxt.rdata = {6'h00, s_r.int_en};
        default:       s_nxt.rdata = 8'h00;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // State register
  // -------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_r <= STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // -------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------
  assign reg_rdata      = s_r.rdata;
  assign sample_out     = s_r.out;
  assign applied_gain_q = s_r.applied;
  assign channel_muted  = (s_r.applied == MUTE_Q);
  assign gain_master    = s_r.master;
  assign sar_req        = (s_r.sar_st == SAR_WAIT);
  assign sar_clk_sel    = s_r.pot_clk;
  assign irq            = |(s_r.int_stat & s_r.int_en);

  // Flag stays up until power is released and the ramp has landed, except that a settled gain
  // lets it drop for the first cycle after release, while the reached flag still holds its old value
  assign dac_power_flag = dac_power_req || !s_r.reached;

endmodule

`default_nettype wire

//--- dvs_volume_props.sv
/*
  Port checker of the volume stage: read port, stream, gain, SAR handshake.
  Assumes it is bound to dvs_volume and sees its ports only.
*/
`timescale 1ns/1ns
`default_nettype none

module dvs_volume_props
  import dvs_pkg::*;
(
  input wire logic               ref_clk,
  input wire logic               sys_rst,
  input wire logic               reg_rd,
  input wire logic        [7:0]  reg_rdata,
  input wire dvs_sample_s        sample_in,
  input wire dvs_sample_s        sample_out,
  input wire logic signed [10:0] applied_gain_q,
  input wire logic               channel_muted,
  input wire logic               dac_power_req,
  input wire logic               dac_power_flag,
  input wire logic               sar_req,
  input wire logic               sar_ack
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  // One clock domain, so clock and reset are given once
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside the answer cycle");
  a_out_follows: assert property (sample_in.valid |=> sample_out.valid)
    else $error("output sample missing");
  a_out_lone: assert property (!sample_in.valid |=> !sample_out.valid)
    else $error("output sample without input");
  a_mute_level: assert property (
    channel_muted == (applied_gain_q == -11'sh208))
    else $error("mute flag disagrees with applied gain");
  a_gain_range: assert property (
    applied_gain_q >= -11'sh208 && applied_gain_q <= 11'sh0c0)
    else $error("applied gain out of range");
  a_power_hold: assert property (dac_power_req |-> dac_power_flag)
    else $error("power flag low while powered");
  // Request must wait for the synchronised acknowledge
  a_req_hold: assert property (sar_req && !sar_ack |=> sar_req)
    else $error("request dropped before acknowledge");
  a_req_release: assert property ($fell(sar_req) |-> $past(sar_ack, 2))
    else $error("request released without acknowledge");
  a_req_start: assert property ($rose(sar_req) |-> !$past(sar_ack))
    else $error("request raised while acknowledge high");

  c_sar_done: cover property ($fell(sar_req));
  c_unmute: cover property ($fell(channel_muted));
  c_flag_low: cover property (!dac_power_flag);
endmodule

`default_nettype wire

//--- dvs_pot_model.sv
/*
  Model of the volume-pin SAR converter behind its four-phase handshake.
  Assumes requests on ref_clk; code is valid only while acknowledge is high.
*/
`timescale 1ns/1ns
`default_nettype none

module dvs_pot_model (
  input  wire logic       ref_clk,
  input  wire logic [6:0] pot_level,  // Code the divider voltage gives
  input  wire logic [3:0] latency,    // Conversion time in cycles, minus one
  input  wire logic       sar_req,
  output logic            sar_ack,
  output logic      [6:0] sar_code
);
  logic [3:0] wait_cnt;

  initial begin
    sar_ack = 1'b0;
    sar_code = 7'h55;
    wait_cnt = 4'h0;
  end

  // Code toggles while not acknowledged, except on the edge that loads it, so a stale read shows up
  always @(posedge ref_clk) begin
    if (sar_req && !sar_ack) begin
      if (wait_cnt == latency) begin
        sar_code <= pot_level;
        sar_ack <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
        sar_code <= ~sar_code;
      end
    end else if (!sar_req && sar_ack) begin
      sar_ack <= 1'b0;
      wait_cnt <= 4'h0;
      sar_code <= ~sar_code;
    end else if (!sar_ack) begin
      sar_code <= ~sar_code;
    end
  end
endmodule

`default_nettype wire

//--- dvs_volume_tb_top.sv
/*
  Self-checking bench of the volume stage.
  Drives the register port and sample stream; a model answers the SAR.
*/
`timescale 1ns/1ns
`default_nettype none

module dvs_volume_tb_top import dvs_pkg::*;;
  logic               ref_clk, sys_rst, reg_wr, reg_rd, dac_power_req;
  logic               sar_req, sar_ack, sar_clk_sel, irq, channel_muted;
  logic               gain_master, dac_power_flag;
  logic        [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic        [6:0]  sar_code, pot_level;
  logic        [3:0]  latency;
  logic        [23:0] seq, last_out;
  logic signed [10:0] applied_gain_q;
  dvs_sample_s        sample_in, sample_out;
  int                 fails, check_count, cycles, n;
  int dly[4] = '{DELAY_A, DELAY_B, DELAY_C, DELAY_A};
  logic [6:0] codes[6] = '{7'h00, 7'h24, 7'h5a, 7'h5b, 7'h7e, 7'h7f};
  logic [7:0] vols[4] = '{8'h30, 8'h7f, 8'h81, 8'h80};
  int vexp[4] = '{192, 192, -508, -508};
  logic [7:0] rst_addr[10] = '{REG_STEP_CTRL, REG_MUTE_CTRL, REG_VOL_GAIN,
    REG_FILT_SEL, REG_GAIN_STAT, REG_POT_CTRL, REG_POT_GAIN, REG_INT_STAT,
    REG_INT_EN, 8'h0a};

  dvs_volume dut (.ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .sample_in, .sample_out, .applied_gain_q,
    .channel_muted, .gain_master, .dac_power_req, .dac_power_flag,
    .sar_req, .sar_ack, .sar_code, .sar_clk_sel, .irq);
  dvs_pot_model u_pot (.ref_clk, .pot_level, .latency, .sar_req, .sar_ack,
    .sar_code);

  // Reference clock never stops; it clocks the stage, the SAR model and the run-length ceiling
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Last output sample, and a ceiling on run length
  always @(posedge ref_clk) begin
    if (sample_out.valid) last_out <= sample_out.data;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      test_done();
    end
  end

  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic smp(input int k);
    repeat (k) begin
      @(posedge ref_clk);
      sample_in <= '{1'b1, seq};
      @(posedge ref_clk);
      sample_in.valid <= 1'b0;
      seq = seq + 24'h1;
    end
    #1;
  endtask
  // Samples until a conversion starts, then let the handshake finish
  task automatic pot(input logic [6:0] c, output int k);
    @(posedge ref_clk);
    pot_level <= c;
    k = 0;
    while (!sar_req && k < 300) begin
      smp(1);
      k++;
    end
    while (sar_req) cyc(1);
    cyc(6);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    {sys_rst, dac_power_req, reg_wr, reg_rd} = 4'hc;
    {reg_addr, reg_wdata, seq, sample_in} = '0;
    {fails, check_count, cycles} = '0;
    pot_level = 7'h00;
    latency = 4'h1;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    cyc(1);
    chk(32'(applied_gain_q), -520);
    chk(channel_muted, 1);
    foreach (rst_addr[i]) rdc(rst_addr[i], 8'h00);
    smp(1);
    chk(32'(applied_gain_q), -519);
    smp(518);
    rdc(REG_GAIN_STAT, 8'h00);
    smp(1);
    chk(32'(applied_gain_q), 0);
    rdc(REG_GAIN_STAT, 8'h10);
    rdc(REG_INT_STAT, 8'h01);
    chk(sar_req, 0);
    $display("test ramp done");
    wr(REG_STEP_CTRL, 8'h01);
    wr(REG_VOL_GAIN, 8'h02);
    smp(1);
    chk(32'(applied_gain_q), 0);
    smp(3);
    chk(32'(applied_gain_q), 2);
    for (int m = 2; m < 4; m++) begin
      wr(REG_STEP_CTRL, 8'(m));
      wr(REG_VOL_GAIN, 8'(m * 4 - 10));
      cyc(2);
      chk(32'(applied_gain_q), (m * 4 - 10) * 4);
    end
    foreach (vols[i]) begin
      wr(REG_VOL_GAIN, vols[i]);
      cyc(2);
      chk(32'(applied_gain_q), vexp[i]);
    end
    @(posedge ref_clk);
    dac_power_req <= 1'b0;
    cyc(3);
    chk(dac_power_flag, 0);
    @(posedge ref_clk);
    dac_power_req <= 1'b1;
    $display("test stepping done");
    wr(REG_MUTE_CTRL, 8'h0a);
    cyc(2);
    chk({channel_muted, gain_master}, 3);
    rdc(REG_GAIN_STAT, 8'h10);
    wr(REG_MUTE_CTRL, 8'h00);
    cyc(2);
    chk({channel_muted, gain_master}, 0);
    wr(REG_INT_EN, 8'h01);
    cyc(1);
    chk(irq, 1);
    wr(REG_INT_CLR, 8'h01);
    cyc(1);
    chk(irq, 0);
    // Jump mode never shows a gap, so step four eighths to re-arm
    wr(REG_STEP_CTRL, 8'h00);
    wr(REG_VOL_GAIN, 8'h82);
    smp(1);
    rdc(REG_GAIN_STAT, 8'h00);
    smp(3);
    chk(irq, 1);
    wr(REG_STEP_CTRL, 8'h02);
    wr(REG_INT_EN, 8'h00);
    cyc(1);
    chk(irq, 0);
    $display("test mute and interrupt done");
    for (int f = 0; f < 4; f++) begin
      wr(REG_FILT_SEL, 8'(f));
      smp(30);
      cyc(1);
      chk(last_out, seq - 24'h1 - 24'(dly[f]));
    end
    $display("test filter delay done");
    wr(REG_POT_CTRL, 8'hc0);
    chk(sar_clk_sel, 1);
    foreach (codes[i]) begin
      @(posedge ref_clk);
      latency <= i[0] ? 4'h9 : 4'h1;
      pot(codes[i], n);
      chk(n, 16);
      chk(32'(applied_gain_q), codes[i] == 7'h7f ? -520 :
        codes[i] <= 7'h5a ? 144 - 4 * codes[i] : 8 * (63 - codes[i]));
      rdc(REG_POT_GAIN, 8'(codes[i]));
    end
    wr(REG_POT_CTRL, 8'h81);
    pot(7'h05, n);
    chk(n, 32);
    wr(REG_VOL_GAIN, 8'h00);
    cyc(2);
    chk(32'(applied_gain_q), 124);
    wr(REG_POT_CTRL, 8'h00);
    wr(REG_VOL_GAIN, 8'h00);
    cyc(2);
    chk(32'(applied_gain_q), 0);
    $display("test volume pin done");
    test_done();
  end
endmodule

bind dvs_volume dvs_volume_props u_props (.ref_clk, .sys_rst, .reg_rd,
  .reg_rdata, .sample_in, .sample_out, .applied_gain_q, .channel_muted,
  .dac_power_req, .dac_power_flag, .sar_req, .sar_ack);

`default_nettype wire
